// ---- shared/isx_consts.svh ----
// constants for the 16-bit stack bus extension owner
`ifndef ISX_CONSTS_SVH
`define ISX_CONSTS_SVH

// ****************************************************************
// timing
// ****************************************************************
`define ISX_CLK_MHZ 50
`define ISX_STRB_NS 250
`define ISX_STRB_CYC ((`ISX_STRB_NS * `ISX_CLK_MHZ + 999) / 1000)

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define ISX_ADDR_W 24
`define ISX_LA_LSB 17
`define ISX_SA_W 20
`define ISX_IRQ_N 5
`define ISX_STRB_IDLE 1'b1
`define ISX_DACK_IDLE 1'b1

`endif

// ---- shared/isx_pkg.sv ----
// types for the 16-bit stack bus extension owner
package isx_pkg;

   // ****************************************************************
   // cycle states
   // ****************************************************************
   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_ADDR = 5'h02,
      S_DEC = 5'h04,
      S_STRB = 5'h08,
      S_REC = 5'h10
   } isx_state_e;

   // ****************************************************************
   // user request
   // ****************************************************************
   typedef struct packed {
      logic write;
      logic mem;
      logic word;
      logic [23:0] addr;
      logic [15:0] wdata;
   } isx_req_s;

endpackage : isx_pkg

// ---- verilog/isx_dma0_arb.sv ----
// channel 0 request and acknowledge arbiter
`timescale 1ns/1ps
`include "isx_consts.svh"

module isx_dma0_arb
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic drq0,
   input wire logic owner_idle,
   output logic grant_next,
   output logic granted,
   output logic dack0_n
);

   // grant only from idle, hold until the requester drops its request
   always_comb
   begin
      grant_next = granted ? drq0 : (drq0 && owner_idle);
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         granted <= 1'b0;
         dack0_n <= `ISX_DACK_IDLE;
      end
      else
      begin
         granted <= grant_next;
         dack0_n <= ~grant_next;
      end
   end

   property p_dack_needs_drq;
      @(posedge clock) disable iff (!resetn)
      $fell(dack0_n) |-> $past(drq0);
   endproperty
   a_dack_needs_drq: assert property (p_dack_needs_drq)
      else $error("acknowledge without request");

   property p_dack_release;
      @(posedge clock) disable iff (!resetn)
      (!dack0_n && !drq0) |=> dack0_n;
   endproperty
   a_dack_release: assert property (p_dack_release)
      else $error("acknowledge held after request dropped");

endmodule : isx_dma0_arb

// ---- verilog/isx_bus_owner.sv ----
// bus owner for the 16-bit stack bus extension rows
`timescale 1ns/1ps
`include "isx_consts.svh"

// What this block does
// - drive byte-high enable low whenever data uses the upper lane
// - memory read strobe on every memory read; slave drives data
// - memory write strobe on every memory write; slave stores data
// - channel 0 acknowledge selects the requesting resource
// - channel 0 acknowledge also grants bus to a would-be master
// - master may take the bus from dma via channel 0 pair
module isx_bus_owner
#(
   parameter int STRB_CYC = `ISX_STRB_CYC
)
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic req_valid,
   input isx_pkg::isx_req_s req_in,
   output logic req_ready,
   output logic done,
   output logic [15:0] rdata,
   output logic bale,
   output logic [6:0] la,
   output logic [19:0] sa,
   output logic sbhe_n,
   output logic memr_n,
   output logic memw_n,
   output logic ior_n,
   output logic iow_n,
   output logic ctl_oe,
   input wire logic [15:0] sd_in,
   output logic [15:0] sd_out,
   output logic sd_oe_lo,
   output logic sd_oe_hi,
   input wire logic memcs16_n,
   input wire logic iocs16_n,
   input wire logic [4:0] irq_in,
   output logic [4:0] irq_req,
   input wire logic drq0,
   output logic dack0_n,
   output logic master_grant
);

   // ****************************************************************
   // state
   // ****************************************************************
   isx_pkg::isx_state_e state;
   isx_pkg::isx_req_s req;
   logic phase_hi, split, wide, lane_hi;
   logic [7:0] cnt;
   logic accept, grant_next, granted;
   logic cs16_n, dec_wide, next_idle;

   assign accept = req_valid && req_ready;
   assign cs16_n = req.mem ? memcs16_n : iocs16_n;
   assign dec_wide = req.word && !req.addr[0] && !cs16_n;
   assign next_idle = (state == isx_pkg::S_IDLE && !accept) ||
                      (state == isx_pkg::S_REC && !(split && !phase_hi));

   // ****************************************************************
   // channel 0 arbiter
   // ****************************************************************
   isx_dma0_arb u_arb
   (
      .clock(clock),
      .resetn(resetn),
      .drq0(drq0),
      .owner_idle(state == isx_pkg::S_IDLE && !accept),
      .grant_next(grant_next),
      .granted(granted),
      .dack0_n(dack0_n)
   );

   // bus is handed over with the acknowledge, drivers let go at once
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         ctl_oe <= 1'b1;
         master_grant <= 1'b0;
         req_ready <= 1'b0;
      end
      else
      begin
         ctl_oe <= ~grant_next;
         master_grant <= grant_next;
         req_ready <= next_idle && !drq0 && !grant_next;
      end
   end

   // ****************************************************************
   // interrupt requests, sampled as levels
   // ****************************************************************
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         irq_req <= 5'h00;
      else
         irq_req <= irq_in;
   end

   // ****************************************************************
   // cycle sequencer
   // ****************************************************************
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         state <= isx_pkg::S_IDLE;
         req <= '0;
         phase_hi <= 1'b0;
         split <= 1'b0;
         wide <= 1'b0;
         lane_hi <= 1'b0;
         cnt <= 8'h00;
         done <= 1'b0;
         rdata <= 16'h0000;
         bale <= 1'b0;
         la <= 7'h00;
         sa <= 20'h00000;
         sbhe_n <= 1'b1;
         memr_n <= `ISX_STRB_IDLE;
         memw_n <= `ISX_STRB_IDLE;
         ior_n <= `ISX_STRB_IDLE;
         iow_n <= `ISX_STRB_IDLE;
         sd_out <= 16'h0000;
         sd_oe_lo <= 1'b0;
         sd_oe_hi <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         unique case (state)
            isx_pkg::S_IDLE:
            begin
               if (accept)
               begin
                  req <= req_in;
                  phase_hi <= 1'b0;
                  split <= 1'b0;
                  bale <= 1'b1;
                  la <= req_in.addr[23:17];
                  sa <= req_in.addr[19:0];
                  sbhe_n <= ~(req_in.word | req_in.addr[0]);
                  state <= isx_pkg::S_ADDR;
               end
            end
            isx_pkg::S_ADDR:
            begin
               // slaves latch upper address on this falling edge of bale
               bale <= 1'b0;
               state <= isx_pkg::S_DEC;
            end
            isx_pkg::S_DEC:
            begin
               wide <= dec_wide;
               lane_hi <= dec_wide ? 1'b0 : (sa[0] && !cs16_n);
               if (!phase_hi)
                  split <= req.word && !dec_wide;
               if (req.word && !dec_wide && !phase_hi && !sa[0])
                  sbhe_n <= 1'b1;
               if (req.write)
               begin
                  if (dec_wide)
                  begin
                     sd_out <= req.wdata;
                     sd_oe_lo <= 1'b1;
                     sd_oe_hi <= 1'b1;
                  end
                  else if (sa[0] && !cs16_n)
                  begin
                     sd_out <= {(phase_hi ? req.wdata[15:8] : req.wdata[7:0]), 8'h00};
                     sd_oe_hi <= 1'b1;
                  end
                  else
                  begin
                     sd_out <= {8'h00, (phase_hi ? req.wdata[15:8] : req.wdata[7:0])};
                     sd_oe_lo <= 1'b1;
                  end
               end
               memr_n <= ~(req.mem && !req.write);
               memw_n <= ~(req.mem && req.write);
               ior_n <= ~(!req.mem && !req.write);
               iow_n <= ~(!req.mem && req.write);
               cnt <= 8'(STRB_CYC - 1);
               state <= isx_pkg::S_STRB;
            end
            isx_pkg::S_STRB:
            begin
               if (cnt != 8'h00)
                  cnt <= cnt - 8'h01;
               else
               begin
                  if (!req.write)
                  begin
                     if (wide)
                        rdata <= sd_in;
                     else if (phase_hi)
                        rdata[15:8] <= lane_hi ? sd_in[15:8] : sd_in[7:0];
                     else
                        rdata[7:0] <= lane_hi ? sd_in[15:8] : sd_in[7:0];
                  end
                  memr_n <= `ISX_STRB_IDLE;
                  memw_n <= `ISX_STRB_IDLE;
                  ior_n <= `ISX_STRB_IDLE;
                  iow_n <= `ISX_STRB_IDLE;
                  state <= isx_pkg::S_REC;
               end
            end
            isx_pkg::S_REC:
            begin
               sd_oe_lo <= 1'b0;
               sd_oe_hi <= 1'b0;
               if (split && !phase_hi)
               begin
                  // second byte goes to the odd address
                  phase_hi <= 1'b1;
                  bale <= 1'b1;
                  sa <= {req.addr[19:1], 1'b1};
                  sbhe_n <= 1'b0;
                  state <= isx_pkg::S_ADDR;
               end
               else
               begin
                  sbhe_n <= 1'b1;
                  done <= 1'b1;
                  state <= isx_pkg::S_IDLE;
               end
            end
         endcase
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   property p_hi_lane_sbhe;
      @(posedge clock) disable iff (!resetn)
      (sd_oe_hi && (!memw_n || !iow_n)) |-> !sbhe_n;
   endproperty
   a_hi_lane_sbhe: assert property (p_hi_lane_sbhe)
      else $error("upper lane driven without byte-high enable");
   property p_memr_on_read;
      @(posedge clock) disable iff (!resetn)
      (state == isx_pkg::S_DEC && req.mem && !req.write) |=> !memr_n [*2];
   endproperty
   a_memr_on_read: assert property (p_memr_on_read)
      else $error("memory read strobe missing");
   property p_memw_on_write;
      @(posedge clock) disable iff (!resetn)
      (state == isx_pkg::S_DEC && req.mem && req.write) |=> (!memw_n && memr_n);
   endproperty
   a_memw_on_write: assert property (p_memw_on_write)
      else $error("memory write strobe missing");
   property p_no_drive_when_granted;
      @(posedge clock) disable iff (!resetn)
      !dack0_n |-> (!ctl_oe && master_grant && memr_n && memw_n && !sd_oe_lo && !sd_oe_hi);
   endproperty
   a_no_drive_when_granted: assert property (p_no_drive_when_granted)
      else $error("owner still drives while bus granted");
   property p_grant_only_idle;
      @(posedge clock) disable iff (!resetn)
      $fell(dack0_n) |-> (granted && state == isx_pkg::S_IDLE && memr_n && memw_n);
   endproperty
   a_grant_only_idle: assert property (p_grant_only_idle)
      else $error("bus granted during an owner cycle");
   property p_split_two_cycles;
      @(posedge clock) disable iff (!resetn)
      (state == isx_pkg::S_REC && split && !phase_hi) |=> (bale && !sbhe_n && sa[0]);
   endproperty
   a_split_two_cycles: assert property (p_split_two_cycles)
      else $error("second byte transfer not started");
   property p_wide_needs_cs16;
      @(posedge clock) disable iff (!resetn)
      (state == isx_pkg::S_DEC && req.word && cs16_n) |=> !wide;
   endproperty
   a_wide_needs_cs16: assert property (p_wide_needs_cs16)
      else $error("wide cycle without 16-bit select");
   property p_strobe_width;
      @(posedge clock) disable iff (!resetn)
      $fell(memr_n) |-> (!memr_n [*2]) ##0 (state == isx_pkg::S_STRB);
   endproperty
   a_strobe_width: assert property (p_strobe_width)
      else $error("read strobe too short");

endmodule : isx_bus_owner

// ---- testbench/isx_slave_model.sv ----
// far side model: memory and io slave boards on the extension rows
`timescale 1ns/1ps

module isx_slave_model
#(
   parameter logic [6:0] WIDE_LA = 7'h01,
   parameter logic [7:0] WIDE_IO = 8'h03
)
(
   input wire logic clock,
   input wire logic bale,
   input wire logic [6:0] la,
   input wire logic [19:0] sa,
   input wire logic sbhe_n,
   input wire logic memr_n,
   input wire logic memw_n,
   input wire logic ior_n,
   input wire logic iow_n,
   input wire logic [15:0] sd_out,
   input wire logic sd_oe_lo,
   input wire logic sd_oe_hi,
   output logic [15:0] sd_in,
   output logic memcs16_n,
   output logic iocs16_n
);
   logic [7:0] mem [0:31];
   logic [6:0] la_lat = 7'h00;
   logic [15:0] last = 16'h0000;
   logic [15:0] drv;
   logic [15:0] bus;
   logic [4:0] a;
   logic rd;
   logic wide;

   initial
   begin
      for (int i = 0; i < 32; i++) mem[i] = 8'h00;
   end

   // la may change mid cycle, so keep our own copy
   always @(negedge bale) la_lat <= la;
   assign memcs16_n = !(la_lat == WIDE_LA);
   assign iocs16_n = !(sa[15:8] == WIDE_IO);
   assign a = sa[4:0];
   assign rd = !memr_n || !ior_n;
   assign wide = (!memr_n || !memw_n) ? !memcs16_n : !iocs16_n;
   assign drv = wide ? {mem[a | 5'h01], mem[a & 5'h1e]} : {~last[15:8], mem[a]};
   // a released lane shows the inverse of its last value, never a stale copy
   assign bus = rd ? drv : ~last;
   assign sd_in = {sd_oe_hi ? sd_out[15:8] : bus[15:8], sd_oe_lo ? sd_out[7:0] : bus[7:0]};

   always @(posedge clock)
   begin
      last <= sd_in;
      if (!memw_n || !iow_n)
      begin
         if (!wide || !a[0]) mem[a] <= sd_in[7:0];
         if (wide && !sbhe_n) mem[a | 5'h01] <= sd_in[15:8];
      end
   end
endmodule : isx_slave_model

// ---- testbench/tb.sv ----
// self-checking bench for the extension bus owner
`timescale 1ns/1ps

module tb;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic req_valid = 1'b0;
   isx_pkg::isx_req_s req_in = '0;
   logic req_ready, done, bale, sbhe_n, memr_n, memw_n, ior_n, iow_n, ctl_oe;
   logic sd_oe_lo, sd_oe_hi, memcs16_n, iocs16_n, dack0_n, master_grant;
   logic [15:0] rdata, sd_in, sd_out;
   logic [6:0] la;
   logic [19:0] sa;
   logic [4:0] irq_in = 5'h00;
   logic [4:0] irq_req;
   logic drq0 = 1'b0;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;

   always #10 clock = ~clock;

   // short strobe keeps the run brief
   isx_bus_owner #(.STRB_CYC(2)) i_isx_bus_owner (.clock(clock), .resetn(resetn),
      .req_valid(req_valid), .req_in(req_in), .req_ready(req_ready), .done(done),
      .rdata(rdata), .bale(bale), .la(la), .sa(sa), .sbhe_n(sbhe_n), .memr_n(memr_n),
      .memw_n(memw_n), .ior_n(ior_n), .iow_n(iow_n), .ctl_oe(ctl_oe), .sd_in(sd_in),
      .sd_out(sd_out), .sd_oe_lo(sd_oe_lo), .sd_oe_hi(sd_oe_hi), .memcs16_n(memcs16_n),
      .iocs16_n(iocs16_n), .irq_in(irq_in), .irq_req(irq_req), .drq0(drq0),
      .dack0_n(dack0_n), .master_grant(master_grant));

   isx_slave_model i_isx_slave_model (.clock(clock), .bale(bale), .la(la), .sa(sa),
      .sbhe_n(sbhe_n), .memr_n(memr_n), .memw_n(memw_n), .ior_n(ior_n), .iow_n(iow_n),
      .sd_out(sd_out), .sd_oe_lo(sd_oe_lo), .sd_oe_hi(sd_oe_hi), .sd_in(sd_in),
      .memcs16_n(memcs16_n), .iocs16_n(iocs16_n));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic print_verdict;
      if (error_cnt == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : print_verdict

   // hi: 1 byte-high enable low during a strobe expected, 0 not, 2 skip
   task automatic xfer(input logic wr, mem, word, input logic [23:0] adr,
      input logic [15:0] wd, exp, input logic [1:0] nbale, hi);
      int n;
      logic [1:0] bales;
      logic [3:0] strb;
      logic seen;
      n = 0;
      bales = 2'h0;
      strb = 4'h0;
      seen = 1'b0;
      while (req_ready !== 1'b1)
      begin
         @(posedge clock);
         #1;
      end
      req_valid = 1'b1;
      req_in = '{write: wr, mem: mem, word: word, addr: adr, wdata: wd};
      @(posedge clock);
      #1;
      req_valid = 1'b0;
      while (done !== 1'b1 && n < 200)
      begin
         if (bale === 1'b1) bales++;
         strb = strb | ~{memr_n, memw_n, ior_n, iow_n};
         if (!(memr_n && memw_n && ior_n && iow_n) && sbhe_n === 1'b0) seen = 1'b1;
         @(posedge clock);
         #1;
         n++;
      end
      chk({15'h0000, done}, 16'h0001);
      chk({12'h000, strb}, {12'h000, mem & ~wr, mem & wr, ~mem & ~wr, ~mem & wr});
      if (!wr) chk(word ? rdata : {8'h00, rdata[7:0]}, exp);
      chk({14'h0000, bales}, {14'h0000, nbale});
      if (hi != 2'h2) chk({15'h0000, seen}, {15'h0000, hi[0]});
   endtask : xfer

   task automatic t_mem;
      xfer(1'b1, 1'b1, 1'b1, 24'h020000, 16'hbeef, 16'h0000, 2'h1, 2'h1);
      xfer(1'b0, 1'b1, 1'b1, 24'h020000, 16'h0000, 16'hbeef, 2'h1, 2'h1);
      xfer(1'b1, 1'b1, 1'b1, 24'h000004, 16'h1234, 16'h0000, 2'h2, 2'h1);
      xfer(1'b0, 1'b1, 1'b1, 24'h000004, 16'h0000, 16'h1234, 2'h2, 2'h1);
   endtask : t_mem

   task automatic t_io;
      xfer(1'b1, 1'b0, 1'b1, 24'h000308, 16'h5aa5, 16'h0000, 2'h1, 2'h1);
      xfer(1'b0, 1'b0, 1'b1, 24'h000308, 16'h0000, 16'h5aa5, 2'h1, 2'h1);
      xfer(1'b1, 1'b0, 1'b0, 24'h00030a, 16'h0077, 16'h0000, 2'h1, 2'h0);
      xfer(1'b0, 1'b0, 1'b1, 24'h00030a, 16'h0000, 16'h0077, 2'h1, 2'h1);
      xfer(1'b1, 1'b0, 1'b0, 24'h00020d, 16'h003c, 16'h0000, 2'h1, 2'h2);
      xfer(1'b0, 1'b0, 1'b0, 24'h00020d, 16'h0000, 16'h003c, 2'h1, 2'h2);
   endtask : t_io

   task automatic t_irq;
      // bench is the sole driver of each line
      for (int i = 0; i < 5; i++)
      begin
         irq_in = 5'h01 << i;
         @(posedge clock);
         #1;
         chk({11'h000, irq_req}, {11'h000, 5'h01 << i});
      end
      irq_in = 5'h00;
   endtask : t_irq

   task automatic t_dma;
      int n;
      n = 0;
      while (req_ready !== 1'b1)
      begin
         @(posedge clock);
         #1;
      end
      req_valid = 1'b1;
      req_in = '{write: 1'b0, mem: 1'b0, word: 1'b0, addr: 24'h000200, wdata: 16'h0000};
      @(posedge clock);
      #1;
      req_valid = 1'b0;
      drq0 = 1'b1;
      // grant must wait for the running cycle
      while (done !== 1'b1 && n < 200)
      begin
         chk({15'h0000, dack0_n}, 16'h0001);
         @(posedge clock);
         #1;
         n++;
      end
      repeat (2) @(posedge clock);
      #1;
      chk({13'h0000, dack0_n, master_grant, ctl_oe}, 16'h0002);
      chk({15'h0000, req_ready}, 16'h0000);
      drq0 = 1'b0;
      @(posedge clock);
      #1;
      chk({14'h0000, dack0_n, master_grant}, 16'h0002);
   endtask : t_dma

   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt++;
         print_verdict();
      end
   end

   initial
   begin
      repeat (6) @(posedge clock);
      #1;
      resetn = 1'b1;
      @(posedge clock);
      #1;
      t_mem();
      t_io();
      t_irq();
      t_dma();
      print_verdict();
   end
endmodule : tb
